// >>> logic/tcr_config_bank.sv
/*
  Thermal configuration register bank: the format/overtemperature enable
  register, the fan and voltage option register and two read-only test
  registers, plus the overtemperature pin and fan override they steer.
  Assumes the serial management engine presents one-cycle read and write
  strobes on the clk domain, and that temperatures, limits, maximum duties
  and the lock bit come from logic on the same clock.
*/
// Contract
// - The local overtemperature enable makes the local limit drive the pin, else the pin is a timer input.
// - The second remote enable makes that channel's limit drive the pin, else it is a timer input.
// - A limit of -64 in offset-64 or -128 in twos complement disables that channel.
// - With the lock bit set both configuration registers ignore every write.
// - The two-bit pin function picks fan speed input, overtemperature, alert or GPIO, reset fan speed.
// - The global overtemperature off bit suppresses the output on all channels.
// - On overtemperature fans go to full duty, or to their maximum duty when the ceiling select is 1.
// - Each attenuator bypass bit rescales its voltage channel to 0 V..2.25 V.
// - The two test registers read as zero, reset to zero and cannot be written.
// - The format bit selects twos complement (1) or offset-64 (0) for all temperatures.
`timescale 1ns/10ps
`include "tcr_regs.svh"
module tcr_config_bank #(
  parameter int CHANNELS = 3,
  parameter int FANS = 3
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register index
  input wire logic reg_wr, // write strobe
  input wire tcr_pkg::tcr_byte_t reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  output tcr_pkg::tcr_byte_t reg_rdata, // read data, held
  output logic reg_hit, // last access hit this bank
  input wire logic config_lock, // lock bit of the first config register
  input wire logic [CHANNELS-1:0][7:0] temp, // 0 local, 1 remote one, 2 remote two
  input wire logic [CHANNELS-1:0][7:0] limit, // overtemperature limits
  input wire logic [FANS-1:0][7:0] fan_max_duty, // programmed maximum duties
  input wire logic overtemp_pin_n_in, // dedicated pin level
  output logic overtemp_pin_n_out, // dedicated pin drive value
  output logic overtemp_pin_oe, // dedicated pin drive enable
  input wire logic shared_pin_n_in, // multiplexed pin level
  output logic shared_pin_n_out, // multiplexed pin drive value
  output logic shared_pin_oe, // multiplexed pin drive enable
  output logic overtemp_timer_active, // pin held low by outside
  output tcr_pkg::tcr_pin_func_e shared_pin_function, // multiplexed pin role
  output logic temp_format_select, // 1 twos complement
  output logic offset_range_wide, // offset range select
  output logic gpio_six_dir, // gpio direction
  output logic gpio_six_pol, // gpio polarity
  output logic vid_gpio_select, // vid pins as gpio
  output logic [3:0] attenuator_bypass, // low, core, mid, high rail
  output logic overtemp_active, // any live channel over limit
  output logic fan_force, // fans overridden
  output logic [FANS-1:0][7:0] fan_force_duty // override duty per fan
);
  import tcr_pkg::*;

  // reset images of the two configuration registers
  localparam tcr_byte_t FORMAT_RST = `TCR_RST_FORMAT_CFG;
  localparam tcr_byte_t OPTION_RST = `TCR_RST_OPTION_CFG;

  // role of the multiplexed pin held in an option register image
  function automatic tcr_pin_func_e pin_role(input tcr_byte_t cfg);
    pin_role = tcr_pin_func_e'(cfg[`TCR_MSB_PIN_FUNC:`TCR_LSB_PIN_FUNC]);
  endfunction

  tcr_byte_t format_cfg;
  tcr_byte_t option_cfg;
  tcr_byte_t next_format_cfg;
  tcr_byte_t next_option_cfg;
  tcr_byte_t next_reg_rdata;
  logic next_reg_hit;
  logic format_wr;
  logic option_wr;

  // register writes

  always_comb begin
    format_wr = reg_wr && !config_lock && (reg_addr == `TCR_OFS_FORMAT_CFG);
    option_wr = reg_wr && !config_lock && (reg_addr == `TCR_OFS_OPTION_CFG);
    next_format_cfg = format_cfg;
    next_option_cfg = option_cfg;
    if (format_wr) begin
      next_format_cfg = reg_wdata;
    end
    if (option_wr) begin
      next_option_cfg = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      format_cfg <= `TCR_RST_FORMAT_CFG;
      option_cfg <= `TCR_RST_OPTION_CFG;
    end else begin
      format_cfg <= next_format_cfg;
      option_cfg <= next_option_cfg;
    end
  end

  // register reads, answered one cycle after the strobe

  always_comb begin
    next_reg_rdata = reg_rdata;
    next_reg_hit = reg_hit;
    if (reg_rd) begin
      next_reg_hit = 1'b1;
      unique case (reg_addr)
        `TCR_OFS_FORMAT_CFG: begin
          next_reg_rdata = format_cfg;
        end
        `TCR_OFS_OPTION_CFG: begin
          next_reg_rdata = option_cfg;
        end
        `TCR_OFS_TEST_ONE, `TCR_OFS_TEST_TWO: begin
          next_reg_rdata = `TCR_RST_TEST;
        end
        default: begin
          next_reg_rdata = 8'h00;
          next_reg_hit = 1'b0;
        end
      endcase
    end else if (reg_wr) begin
      next_reg_hit = (reg_addr >= `TCR_OFS_FORMAT_CFG) && (reg_addr <= `TCR_OFS_TEST_TWO);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_hit <= next_reg_hit;
    end
  end

  // configuration fields onto flip-flop outputs

  logic next_temp_format_select;
  logic next_offset_range_wide;
  logic next_gpio_six_dir;
  logic next_gpio_six_pol;
  logic next_vid_gpio_select;
  logic [3:0] next_attenuator_bypass;
  tcr_pin_func_e next_shared_pin_function;

  always_comb begin
    next_temp_format_select = next_format_cfg[`TCR_BIT_TEMP_FORMAT];
    next_offset_range_wide = next_format_cfg[`TCR_BIT_OFFSET_RANGE];
    next_gpio_six_dir = next_format_cfg[`TCR_BIT_GPIO_DIR];
    next_gpio_six_pol = next_format_cfg[`TCR_BIT_GPIO_POL];
    next_vid_gpio_select = next_format_cfg[`TCR_BIT_VID_GPIO];
    next_attenuator_bypass = next_option_cfg[`TCR_MSB_BYPASS:`TCR_LSB_BYPASS];
    next_shared_pin_function = pin_role(next_option_cfg);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_format_select <= FORMAT_RST[`TCR_BIT_TEMP_FORMAT];
      offset_range_wide <= FORMAT_RST[`TCR_BIT_OFFSET_RANGE];
      gpio_six_dir <= FORMAT_RST[`TCR_BIT_GPIO_DIR];
      gpio_six_pol <= FORMAT_RST[`TCR_BIT_GPIO_POL];
      vid_gpio_select <= FORMAT_RST[`TCR_BIT_VID_GPIO];
      attenuator_bypass <= OPTION_RST[`TCR_MSB_BYPASS:`TCR_LSB_BYPASS];
      shared_pin_function <= pin_role(OPTION_RST);
    end else begin
      temp_format_select <= next_temp_format_select;
      offset_range_wide <= next_offset_range_wide;
      gpio_six_dir <= next_gpio_six_dir;
      gpio_six_pol <= next_gpio_six_pol;
      vid_gpio_select <= next_vid_gpio_select;
      attenuator_bypass <= next_attenuator_bypass;
      shared_pin_function <= next_shared_pin_function;
    end
  end

  // per-channel limit compare

  logic [CHANNELS-1:0] chan_enable;
  logic [CHANNELS-1:0] chan_over;

  always_comb begin
    chan_enable = '0;
    chan_enable[0] = format_cfg[`TCR_BIT_LOCAL_EN];
    chan_enable[1] = format_cfg[`TCR_BIT_REMOTE_ONE_EN];
    chan_enable[2] = format_cfg[`TCR_BIT_REMOTE_TWO_EN];
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      tcr_limit_check u_check (
        .twos_mode(format_cfg[`TCR_BIT_TEMP_FORMAT]),
        .enable(chan_enable[ch]),
        .temp(temp[ch]),
        .limit(limit[ch]),
        .over(chan_over[ch])
      );
    end
  endgenerate

  // pin inputs pass two flip-flops before use

  logic pin_sync;
  logic shared_sync;

  tcr_sync2 #(.RESET_VALUE(1'b1)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(overtemp_pin_n_in),
    .sync_out(pin_sync)
  );

  tcr_sync2 #(.RESET_VALUE(1'b1)) u_shared_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(shared_pin_n_in),
    .sync_out(shared_sync)
  );

  // overtemperature decision and pin drive

  logic next_overtemp_active;
  logic next_overtemp_pin_oe;
  logic next_shared_pin_oe;
  logic next_timer_active;
  logic any_driver;
  logic shared_is_overtemp;
  // our own drive shows on the synchronised level two edges late, so it is
  // remembered that long and a released pin is not taken for an outside low
  logic [1:0] pin_oe_echo;
  logic [1:0] shared_oe_echo;
  logic [1:0] next_pin_oe_echo;
  logic [1:0] next_shared_oe_echo;
  logic pin_low_outside;
  logic shared_low_outside;

  always_comb begin
    shared_is_overtemp = (pin_role(option_cfg) == TCR_PIN_OVERTEMP);
    any_driver = |chan_enable && !option_cfg[`TCR_BIT_GLOBAL_OFF];
    next_overtemp_active = (|chan_over) && !option_cfg[`TCR_BIT_GLOBAL_OFF];
    // open drain: drive low only while asserted, otherwise release
    next_overtemp_pin_oe = any_driver && next_overtemp_active;
    next_shared_pin_oe = shared_is_overtemp && any_driver && next_overtemp_active;
    next_pin_oe_echo = {pin_oe_echo[0], overtemp_pin_oe};
    next_shared_oe_echo = {shared_oe_echo[0], shared_pin_oe};
    // a low level not caused by this device counts as the timer input
    pin_low_outside = !pin_sync && !overtemp_pin_oe && !(|pin_oe_echo);
    shared_low_outside = shared_is_overtemp && !shared_sync && !shared_pin_oe
      && !(|shared_oe_echo);
    next_timer_active = pin_low_outside || shared_low_outside;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_active <= 1'b0;
      overtemp_pin_oe <= 1'b0;
      overtemp_pin_n_out <= 1'b1;
      shared_pin_oe <= 1'b0;
      shared_pin_n_out <= 1'b1;
      overtemp_timer_active <= 1'b0;
      pin_oe_echo <= 2'h0;
      shared_oe_echo <= 2'h0;
    end else begin
      overtemp_active <= next_overtemp_active;
      overtemp_pin_oe <= next_overtemp_pin_oe;
      overtemp_pin_n_out <= !next_overtemp_pin_oe;
      shared_pin_oe <= next_shared_pin_oe;
      shared_pin_n_out <= !next_shared_pin_oe;
      overtemp_timer_active <= next_timer_active;
      pin_oe_echo <= next_pin_oe_echo;
      shared_oe_echo <= next_shared_oe_echo;
    end
  end

  // fan override on overtemperature

  logic next_fan_force;
  logic [FANS-1:0][7:0] next_fan_force_duty;

  always_comb begin
    next_fan_force = next_overtemp_active;
    for (int f = 0; f < FANS; f++) begin
      if (!next_overtemp_active) begin
        next_fan_force_duty[f] = 8'h00;
      end else if (option_cfg[`TCR_BIT_CEILING_SEL]) begin
        next_fan_force_duty[f] = fan_max_duty[f];
      end else begin
        next_fan_force_duty[f] = `TCR_DUTY_FULL;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_force <= 1'b0;
      fan_force_duty <= '0;
    end else begin
      fan_force <= next_fan_force;
      fan_force_duty <= next_fan_force_duty;
    end
  end

endmodule // tcr_config_bank

// >>> logic/tcr_regs.svh
/*
  Register offsets, field positions, reset values and limit codes of the
  thermal configuration register bank.
  Assumes byte-wide registers on an 8-bit register index.
*/
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH

`define TCR_OFS_FORMAT_CFG 8'h7C
`define TCR_OFS_OPTION_CFG 8'h7D
`define TCR_OFS_TEST_ONE 8'h7E
`define TCR_OFS_TEST_TWO 8'h7F

`define TCR_RST_FORMAT_CFG 8'h01
`define TCR_RST_OPTION_CFG 8'h00
`define TCR_RST_TEST 8'h00

// format register fields
`define TCR_BIT_TEMP_FORMAT 0
`define TCR_BIT_OFFSET_RANGE 1
`define TCR_BIT_GPIO_DIR 2
`define TCR_BIT_GPIO_POL 3
`define TCR_BIT_VID_GPIO 4
`define TCR_BIT_REMOTE_ONE_EN 5
`define TCR_BIT_LOCAL_EN 6
`define TCR_BIT_REMOTE_TWO_EN 7

// option register fields
`define TCR_LSB_PIN_FUNC 0
`define TCR_MSB_PIN_FUNC 1
`define TCR_BIT_GLOBAL_OFF 2
`define TCR_BIT_CEILING_SEL 3
`define TCR_LSB_BYPASS 4
`define TCR_MSB_BYPASS 7

// limit codes meaning "channel disabled", then the full fan override duty
`define TCR_LIMIT_OFF_OFS64 8'h00
`define TCR_LIMIT_OFF_TWOS 8'h80
`define TCR_DUTY_FULL 8'hFF

`endif

// >>> logic/tcr_pkg.sv
/*
  Types of the thermal configuration register bank.
  Assumes nothing of its surroundings.
*/
package tcr_pkg;

  typedef enum logic [1:0] {
    TCR_PIN_FAN_SPEED = 2'h0,
    TCR_PIN_OVERTEMP = 2'h1,
    TCR_PIN_ALERT = 2'h2,
    TCR_PIN_GPIO = 2'h3
  } tcr_pin_func_e;

  typedef logic [7:0] tcr_byte_t;

endpackage

// >>> logic/tcr_sync2.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
module tcr_sync2 #(
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset
  input wire logic async_in, // asynchronous level
  output logic sync_out // synchronised level
);

  logic stage_one;
  logic next_stage_one;
  logic next_sync_out;

  always_comb begin
    next_stage_one = async_in;
    next_sync_out = stage_one;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage_one <= next_stage_one;
      sync_out <= next_sync_out;
    end
  end

endmodule // tcr_sync2

// >>> logic/tcr_limit_check.sv
/*
  Over-limit compare for one temperature channel.
  Assumes temperature and limit share the format chosen by twos_mode.
*/
`timescale 1ns/10ps
`include "tcr_regs.svh"
module tcr_limit_check (
  input wire logic twos_mode, // 1: twos complement, 0: offset-64
  input wire logic enable, // channel drives the pin
  input wire logic [7:0] temp, // measured temperature
  input wire logic [7:0] limit, // overtemperature limit
  output logic over // channel is over its limit
);
  import tcr_pkg::*;

  // map either format onto an unsigned ordering
  function automatic logic [7:0] ordinal(input logic [7:0] v, input logic twos);
    ordinal = twos ? {~v[7], v[6:0]} : v;
  endfunction

  function automatic logic limit_off(input logic [7:0] v, input logic twos);
    limit_off = twos ? (v == `TCR_LIMIT_OFF_TWOS) : (v == `TCR_LIMIT_OFF_OFS64);
  endfunction

  always_comb begin
    over = enable && !limit_off(limit, twos_mode)
      && (ordinal(temp, twos_mode) > ordinal(limit, twos_mode));
  end

endmodule // tcr_limit_check

// >>> test/tcr_config_monitor.sv
/* Concurrent checks on the ports of tcr_config_bank.
   Assumes it is bound into the bank, one clock and an active-low reset. */
`timescale 1ns/10ps
module tcr_config_monitor #(
  parameter int CHANNELS = 3,
  parameter int FANS = 3
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [7:0] reg_addr, // index
  input wire logic reg_wr, // write
  input wire tcr_pkg::tcr_byte_t reg_wdata, // data
  input wire logic reg_rd, // read
  input wire tcr_pkg::tcr_byte_t reg_rdata, // read data
  input wire logic reg_hit, // hit
  input wire logic config_lock, // lock
  input wire logic [CHANNELS-1:0][7:0] limit, // limits
  input wire logic overtemp_pin_n_in, // pin
  input wire logic overtemp_pin_n_out, // value
  input wire logic overtemp_pin_oe, // enable
  input wire logic shared_pin_n_out, // value
  input wire logic shared_pin_oe, // enable
  input wire logic overtemp_timer_active, // timer
  input wire tcr_pkg::tcr_pin_func_e shared_pin_function, // role
  input wire logic temp_format_select, // format
  input wire logic [3:0] attenuator_bypass, // bypass
  input wire logic overtemp_active, // over
  input wire logic fan_force, // forced
  input wire logic [FANS-1:0][7:0] fan_force_duty // duty
);
  import tcr_pkg::*;
  logic wr_ok;
  assign wr_ok = reg_wr && !config_lock;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_OPTION_WR: assert property (wr_ok && reg_addr == 8'h7D |=>
    shared_pin_function == $past(reg_wdata[1:0]) && attenuator_bypass == $past(reg_wdata[7:4]))
    else $error("option write lost");
  AST_FORMAT_WR: assert property (wr_ok && reg_addr == 8'h7C |=>
    temp_format_select == $past(reg_wdata[0])) else $error("format write lost");
  AST_LOCKED: assert property (reg_wr && config_lock |=> $stable(shared_pin_function) &&
    $stable(attenuator_bypass) && $stable(temp_format_select)) else $error("locked write taken");
  AST_TEST_READ: assert property (reg_rd && reg_addr[7:1] == 7'h3F |=>
    reg_rdata == 8'h00 && reg_hit) else $error("test register not zero");
  AST_GLOBAL_OFF: assert property (wr_ok && reg_addr == 8'h7D && reg_wdata[2] |=>
    ##1 !overtemp_active) else $error("output not suppressed");
  AST_LIMIT_OFF: assert property ((temp_format_select ? limit == {CHANNELS{8'h80}} : limit == '0) |=>
    !overtemp_active) else $error("disabled limits still fire");
  AST_PIN_FAN: assert property (overtemp_pin_oe == overtemp_active && fan_force == overtemp_active &&
    (overtemp_active || fan_force_duty == '0) && !(overtemp_pin_oe && overtemp_pin_n_out))
    else $error("pin or fan override out of step");
  AST_SHARED: assert property (shared_pin_oe |-> !shared_pin_n_out &&
    (shared_pin_function == TCR_PIN_OVERTEMP || $past(shared_pin_function) == TCR_PIN_OVERTEMP))
    else $error("shared pin driven in wrong role");
  AST_TIMER: assert property ((!overtemp_pin_n_in && !overtemp_pin_oe) [*4] |=>
    overtemp_timer_active) else $error("timer input missed");
  cover property (overtemp_active && shared_pin_oe);
  cover property (reg_wr && config_lock);
  cover property (overtemp_timer_active);
endmodule // tcr_config_monitor
bind tcr_config_bank tcr_config_monitor #(.CHANNELS(CHANNELS), .FANS(FANS)) tcr_config_monitor_inst (.*);

// >>> test/tcr_host.sv
/* Host model: single-byte register writes and reads.
   Assumes the bank takes strobes on the rising edge of clk. */
`timescale 1ns/10ps
module tcr_host (
  input wire logic clk, // clock
  output logic [7:0] reg_addr, // index
  output logic reg_wr, // write strobe
  output tcr_pkg::tcr_byte_t reg_wdata, // write data
  output logic reg_rd, // read strobe
  input wire tcr_pkg::tcr_byte_t reg_rdata // read data
);
  import tcr_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // test registers are written only where a scenario asks it
  task automatic put(input logic [7:0] a, input tcr_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    reg_addr <= ~a;
  endtask
  // read data stands from the edge after the strobe
  task automatic get(input logic [7:0] a, output tcr_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule // tcr_host

// >>> test/tb_top.sv
/* Self-checking bench of tcr_config_bank through the host model.
   Assumes the monitor binds itself to the bank. */
`timescale 1ns/10ps
module tb_top;
  import tcr_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, reg_hit, config_lock, ext_low;
  logic [7:0] reg_addr;
  tcr_byte_t reg_wdata, reg_rdata;
  logic [2:0][7:0] temp, limit, fan_max_duty, fan_force_duty;
  logic overtemp_pin_n_in, overtemp_pin_n_out, overtemp_pin_oe, overtemp_timer_active;
  logic shared_pin_n_in, shared_pin_n_out, shared_pin_oe, fan_force, overtemp_active;
  logic temp_format_select, offset_range_wide, gpio_six_dir, gpio_six_pol, vid_gpio_select;
  logic [3:0] attenuator_bypass;
  tcr_pin_func_e shared_pin_function;
  int miscompares = 0, checks = 0, cycles = 0;
  // both pins pulled up; the outside pulls the dedicated one on ext_low
  assign overtemp_pin_n_in = !(ext_low || (overtemp_pin_oe && !overtemp_pin_n_out));
  assign shared_pin_n_in = !(shared_pin_oe && !shared_pin_n_out);
  tcr_host tcr_host_inst (.*);
  tcr_config_bank tcr_config_bank_inst (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic drive(input int ch, input logic [7:0] l, input logic [7:0] t);
    @(posedge clk);
    limit[ch] <= l;
    temp[ch] <= t;
    settle(2);
  endtask
  task automatic t_regs;
    tcr_byte_t d;
    chk(temp_format_select, 1);
    tcr_host_inst.put(8'h7E, 8'hAA);
    tcr_host_inst.put(8'h7F, 8'h55);
    for (int i = 0; i < 4; i++) begin
      tcr_host_inst.get(8'h7C + 8'(i), d);
      chk({d, reg_hit}, {(i == 0 ? 8'h01 : 8'h00), 1'b1});
    end
    tcr_host_inst.get(8'h10, d);
    chk({d, reg_hit}, 9'h000);
  endtask
  task automatic t_func;
    tcr_byte_t d, v;
    for (int i = 0; i < 4; i++) begin
      v = {4'(1 << i), 2'b00, 2'(i)};
      tcr_host_inst.put(8'h7D, v);
      tcr_host_inst.get(8'h7D, d);
      chk({d, shared_pin_function, attenuator_bypass}, {v, v[1:0], v[7:4]});
    end
  endtask
  task automatic t_over;
    tcr_host_inst.put(8'h7D, 8'h00);
    tcr_host_inst.put(8'h7C, 8'h41);
    drive(0, 8'h10, 8'h11);
    chk({overtemp_active, fan_force, overtemp_pin_n_in, fan_force_duty}, {3'b110, 24'hFFFFFF});
    tcr_host_inst.put(8'h7D, 8'h09);
    settle(2);
    chk({shared_pin_n_in, fan_force_duty}, {1'b0, 24'h302010});
    tcr_host_inst.put(8'h7D, 8'h05);
    settle(2);
    chk({overtemp_active, overtemp_pin_n_in, shared_pin_n_in, overtemp_timer_active}, 4'b0110);
  endtask
  task automatic t_disable;
    tcr_host_inst.put(8'h7D, 8'h00);
    drive(0, 8'h80, 8'h11);
    chk(overtemp_active, 0);
    drive(0, 8'h10, 8'h90);
    chk(overtemp_active, 0);
    tcr_host_inst.put(8'h7C, 8'h40);
    settle(2);
    chk(overtemp_active, 1);
    drive(0, 8'h00, 8'h90);
    chk(overtemp_active, 0);
  endtask
  task automatic t_multi;
    tcr_host_inst.put(8'h7C, 8'h81);
    drive(0, 8'h10, 8'h11);
    chk({overtemp_active, overtemp_pin_n_in}, 2'b01);
    drive(2, 8'h20, 8'h30);
    chk({overtemp_active, overtemp_pin_n_in}, 2'b10);
    tcr_host_inst.put(8'h7C, 8'hC1);
    drive(2, 8'h20, 8'h00);
    chk(overtemp_active, 1);
    drive(0, 8'h10, 8'h00);
    chk(overtemp_active, 0);
  endtask
  task automatic t_lock;
    tcr_byte_t d;
    @(posedge clk);
    config_lock <= 1'b1;
    tcr_host_inst.put(8'h7D, 8'hF3);
    tcr_host_inst.put(8'h7C, 8'h00);
    tcr_host_inst.get(8'h7D, d);
    chk(d, 8'h00);
    tcr_host_inst.get(8'h7C, d);
    chk({d, temp_format_select}, {8'hC1, 1'b1});
    @(posedge clk);
    config_lock <= 1'b0;
  endtask
  task automatic t_timer;
    tcr_host_inst.put(8'h7C, 8'h1E);
    @(posedge clk);
    limit <= '0;
    temp <= {3{8'h50}};
    ext_low <= 1'b1;
    settle(4);
    chk({overtemp_active, overtemp_timer_active}, 2'b01);
    chk({temp_format_select, vid_gpio_select, gpio_six_pol, gpio_six_dir, offset_range_wide}, 5'h0F);
    @(posedge clk);
    ext_low <= 1'b0;
    settle(4);
    chk(overtemp_timer_active, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    config_lock = 1'b0;
    ext_low = 1'b0;
    temp = '0;
    limit = {3{8'h7F}};
    fan_max_duty = {8'h30, 8'h20, 8'h10};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    t_regs;
    t_func;
    t_over;
    t_disable;
    t_multi;
    t_lock;
    t_timer;
    wrap_up;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up;
    end
  end
endmodule // tb_top
